// >>> design/rdr_core.sv
// Ramp sequencer: inter-ramp delay, fast ramp, interrupt readback and fast lock timer
`timescale 1ns/1ps
`include "rdr_map.svh"

module rdr_core #(
  parameter int PFD_DIV = `RDR_PFD_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic div_reg_write,
  input wire logic ramp_enable,
  input wire logic [`RDR_INT_W-1:0] int_value,
  input wire logic [`RDR_FRAC_W-1:0] frac_value,
  input wire logic [1:0] ramp_type,
  input wire logic fast_ramp_en,
  input wire logic dual_rate_en,
  input wire logic delay_en,
  input wire logic delay_clk_sel,
  input wire logic delay_fastlock_en,
  input wire logic [11:0] delay_word,
  input wire logic [11:0] timer_div_one,
  input wire logic [11:0] timer_div_two_set0,
  input wire logic [11:0] timer_div_two_set1,
  input wire logic [`RDR_STEP_W-1:0] step_count_set0,
  input wire logic [`RDR_STEP_W-1:0] step_count_set1,
  input wire logic [`RDR_DEV_W-1:0] per_step_deviation_word_set0,
  input wire logic [`RDR_DEV_W-1:0] per_step_deviation_word_set1,
  input wire logic [3:0] deviation_shift_set0,
  input wire logic [3:0] deviation_shift_set1,
  input wire logic ext_step_en,
  input wire logic [1:0] irq_mode,
  input wire logic [3:0] output_select,
  input wire logic [4:0] readback_select,
  input wire logic [1:0] fastlock_mode,
  input wire logic trigger_pin,
  input wire logic serial_clk,
  output logic multiplexed_output_pin,
  output logic loop_switch_one,
  output logic loop_switch_two,
  output logic wide_bandwidth,
  output logic ramp_active,
  output logic ramp_complete,
  output logic [`RDR_RB_W-1:0] divider_word
);

  rdr_pkg::rdr_state_e state;
  rdr_pkg::rdr_state_e next_state;
  logic [7:0] pfd_div_cnt;
  logic pfd_tick;
  logic trig_q;
  logic sclk_q;
  logic set_sel;
  logic first_delay;
  logic [`RDR_TMR_W-1:0] ramp_cnt;
  logic [`RDR_TMR_W-1:0] fl_cnt;
  logic [`RDR_STEP_W-1:0] step_idx;
  logic [`RDR_RB_W-1:0] rb_shift;
  logic rb_bit;

  // Edge detection; pins are taken as synchronous to core_clk
  wire trig_rise = trigger_pin & ~trig_q;
  wire sclk_rise = serial_clk & ~sclk_q;

  // Parameter set selection for the running slope
  wire [11:0] cur_clk2 = set_sel ? timer_div_two_set1 : timer_div_two_set0;
  wire [`RDR_STEP_W-1:0] cur_steps = set_sel ? step_count_set1 : step_count_set0;
  wire [`RDR_DEV_W-1:0] cur_dev = set_sel ? per_step_deviation_word_set1 : per_step_deviation_word_set0;
  wire [3:0] cur_shift = set_sel ? deviation_shift_set1 : deviation_shift_set0;

  // Scaled deviation, sign extended to the divider width
  wire [`RDR_RB_W-1:0] dev_ext = {{(`RDR_RB_W-`RDR_DEV_W){cur_dev[`RDR_DEV_W-1]}}, cur_dev};
  wire [`RDR_RB_W-1:0] delta = dev_ext << cur_shift;
  wire [`RDR_RB_W-1:0] base_word = {int_value, frac_value};

  // Timer reload values; zero is treated as one period so a timer never stalls
  wire [`RDR_TMR_W-1:0] step_load = {12'h000, timer_div_one} * {12'h000, cur_clk2};
  wire [`RDR_TMR_W-1:0] fl_load = {12'h000, timer_div_one} * {12'h000, timer_div_two_set0};
  wire [`RDR_TMR_W-1:0] delay_load = delay_clk_sel ? {12'h000, delay_word} * {12'h000, timer_div_one}
                                                   : {12'h000, delay_word};

  // Event decode
  wire running = (state == rdr_pkg::ST_UP) || (state == rdr_pkg::ST_DOWN) || (state == rdr_pkg::ST_DELAY);
  wire tmr_exp = pfd_tick && (ramp_cnt <= `RDR_TMR_W'(1));
  wire irq_evt = trig_rise && (irq_mode != `RDR_IRQ_OFF) && running;
  wire halt_evt = irq_evt && (irq_mode == `RDR_IRQ_HALT);
  wire slope = (state == rdr_pkg::ST_UP) || (state == rdr_pkg::ST_DOWN);
  wire step_evt = slope && !halt_evt && (ext_step_en ? trig_rise : tmr_exp);
  wire last_step = (step_idx + `RDR_STEP_W'(1)) >= cur_steps;
  wire is_tri = fast_ramp_en || (ramp_type == `RDR_RAMP_TRI);
  wire burst_end = step_evt && last_step && ((state == rdr_pkg::ST_DOWN) || !is_tri);
  wire fl_start = div_reg_write && !ramp_enable && (fastlock_mode == `RDR_FL_DIV_MODE);
  wire delay_wide = (state == rdr_pkg::ST_DELAY) && first_delay && delay_fastlock_en;
  wire next_wide = (fl_cnt != `RDR_TMR_W'(0)) || delay_wide;
  wire mux_rb = output_select == `RDR_MUX_SEL_RB;
  // A halted sweep is still an active ramp, so its captured word stays readable
  wire ramp_on = (state != rdr_pkg::ST_IDLE);
  wire next_mux = mux_rb && (readback_select == `RDR_RB_SEL_DONE) ? ramp_complete :
                  mux_rb && (readback_select == `RDR_RB_SEL_FREQ) ? (rb_bit & ramp_on) : 1'b0;

  // Next state of the ramp sequencer
  always_comb begin
    next_state = state;
    case (state)
      rdr_pkg::ST_IDLE: begin
        next_state = rdr_pkg::ST_IDLE;
      end
      rdr_pkg::ST_UP: begin
        if (halt_evt) begin
          next_state = rdr_pkg::ST_HALT;
        end else if (step_evt && last_step) begin
          next_state = is_tri ? rdr_pkg::ST_DOWN : (delay_en ? rdr_pkg::ST_DELAY : rdr_pkg::ST_UP);
        end
      end
      rdr_pkg::ST_DOWN: begin
        if (halt_evt) begin
          next_state = rdr_pkg::ST_HALT;
        end else if (step_evt && last_step) begin
          next_state = delay_en ? rdr_pkg::ST_DELAY : rdr_pkg::ST_UP;
        end
      end
      rdr_pkg::ST_DELAY: begin
        if (halt_evt) begin
          next_state = rdr_pkg::ST_HALT;
        end else if (tmr_exp) begin
          next_state = rdr_pkg::ST_UP;
        end
      end
      default: begin
        next_state = rdr_pkg::ST_HALT;
      end
    endcase
    if (div_reg_write) begin
      next_state = ramp_enable ? rdr_pkg::ST_UP : rdr_pkg::ST_IDLE;
    end
  end

  // Phase-detector rate enable from the core clock
  // A divider write realigns the tick phase, so every interval it starts
  // lasts a whole number of PHASE_DETECTOR periods counted from the write itself
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pfd_div_cnt <= 8'h00;
      pfd_tick <= 1'b0;
    end else if (div_reg_write) begin
      pfd_div_cnt <= 8'h01;
      pfd_tick <= 1'b0;
    end else begin
      pfd_tick <= (pfd_div_cnt == 8'(PFD_DIV - 1));
      pfd_div_cnt <= (pfd_div_cnt == 8'(PFD_DIV - 1)) ? 8'h00 : pfd_div_cnt + 8'h01;
    end
  end

  // Pin history for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      trig_q <= trigger_pin;
      sclk_q <= serial_clk;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= rdr_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Step and delay timer: reloaded on each interval start, counts PHASE_DETECTOR ticks
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_cnt <= `RDR_TMR_W'(0);
    end else if (div_reg_write || (step_evt && !(burst_end && delay_en))) begin
      ramp_cnt <= step_load;
    end else if (burst_end && delay_en) begin
      ramp_cnt <= delay_load;
    end else if (state == rdr_pkg::ST_DELAY && tmr_exp) begin
      ramp_cnt <= step_load;
    end else if (pfd_tick && ramp_cnt != `RDR_TMR_W'(0)) begin
      ramp_cnt <= ramp_cnt - `RDR_TMR_W'(1);
    end
  end

  // Divider word and step index; triangles step down by the same count, except under fast ramp, where the down slope uses set 1
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divider_word <= `RDR_RB_W'(0);
      step_idx <= `RDR_STEP_W'(0);
    end else if (div_reg_write) begin
      divider_word <= base_word;
      step_idx <= `RDR_STEP_W'(0);
    end else if (step_evt) begin
      divider_word <= (state == rdr_pkg::ST_DOWN) ? divider_word - delta : divider_word + delta;
      step_idx <= last_step ? `RDR_STEP_W'(0) : step_idx + `RDR_STEP_W'(1);
      if (burst_end && !is_tri) begin
        divider_word <= base_word;
      end
    end
  end

  // Set select: fast ramp ties set to slope, dual rate alternates per burst
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      set_sel <= 1'b0;
    end else if (div_reg_write) begin
      set_sel <= 1'b0;
    end else if (step_evt && last_step) begin
      if (fast_ramp_en) begin
        set_sel <= (state == rdr_pkg::ST_UP);
      end else if (dual_rate_en && burst_end) begin
        set_sel <= ~set_sel;
      end
    end
  end

  // First delay after a start gets the optional wide bandwidth
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_delay <= 1'b0;
    end else if (div_reg_write) begin
      first_delay <= 1'b1;
    end else if (state == rdr_pkg::ST_DELAY && tmr_exp) begin
      first_delay <= 1'b0;
    end
  end

  // Fast lock interval timer; a ramp start cancels it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fl_cnt <= `RDR_TMR_W'(0);
    end else if (fl_start) begin
      fl_cnt <= (fl_load == `RDR_TMR_W'(0)) ? `RDR_TMR_W'(1) : fl_load;
    end else if (div_reg_write) begin
      fl_cnt <= `RDR_TMR_W'(0);
    end else if (pfd_tick && fl_cnt != `RDR_TMR_W'(0)) begin
      fl_cnt <= fl_cnt - `RDR_TMR_W'(1);
    end
  end

  // Readback capture and shift: the capture wins over a same-cycle shift
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_shift <= `RDR_RB_W'(0);
      rb_bit <= 1'b0;
    end else if (irq_evt) begin
      rb_shift <= divider_word;
      rb_bit <= 1'b0;
    end else if (sclk_rise) begin
      rb_bit <= rb_shift[`RDR_RB_W-1];
      rb_shift <= {rb_shift[`RDR_RB_W-2:0], 1'b0};
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_complete <= 1'b0;
      ramp_active <= 1'b0;
      wide_bandwidth <= 1'b0;
      loop_switch_one <= 1'b0;
      loop_switch_two <= 1'b0;
      multiplexed_output_pin <= 1'b0;
    end else begin
      ramp_complete <= burst_end;
      ramp_active <= (next_state != rdr_pkg::ST_IDLE);
      wide_bandwidth <= next_wide;
      loop_switch_one <= next_wide && (fastlock_mode == `RDR_FL_DIV_MODE);
      loop_switch_two <= next_wide && (fastlock_mode == `RDR_FL_DIV_MODE);
      multiplexed_output_pin <= next_mux;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_ramp_start: assert property (div_reg_write && ramp_enable |=> state == rdr_pkg::ST_UP)
    else $error("ramp did not start on divider write");
  a_delay_entry: assert property (burst_end && delay_en && !div_reg_write |=> state == rdr_pkg::ST_DELAY)
    else $error("no delay after burst");
  a_delay_short: assert property (burst_end && delay_en && !delay_clk_sel |=> ramp_cnt == {12'h000, delay_word})
    else $error("delay load wrong");
  a_delay_long: assert property (burst_end && delay_en && delay_clk_sel
                                 |=> ramp_cnt == {12'h000, $past(delay_word)} * {12'h000, $past(timer_div_one)})
    else $error("long delay load wrong");
  a_halt_mode: assert property (halt_evt && !div_reg_write |=> state == rdr_pkg::ST_HALT)
    else $error("halt interrupt did not stop sweep");
  a_irq_off: assert property (irq_mode == `RDR_IRQ_OFF && state != rdr_pkg::ST_HALT && !div_reg_write
                              |=> state != rdr_pkg::ST_HALT)
    else $error("halt with interrupts off");
  a_capture_word: assert property (irq_evt |=> rb_shift == $past(divider_word))
    else $error("readback word not captured");
  a_shift_msb: assert property (sclk_rise && !irq_evt |=> rb_bit == $past(rb_shift[`RDR_RB_W-1]))
    else $error("readback bit not shifted");
  a_no_fl_ramp: assert property (state == rdr_pkg::ST_UP && !delay_fastlock_en |-> ##2 !wide_bandwidth)
    else $error("fast lock during ramp");
  a_switches: assert property (fastlock_mode == `RDR_FL_DIV_MODE ##1 wide_bandwidth |-> loop_switch_one && loop_switch_two)
    else $error("loop switches not driven");
  a_mux_done: assert property (mux_rb && readback_select == `RDR_RB_SEL_DONE |=> multiplexed_output_pin == $past(ramp_complete))
    else $error("ramp complete not on output");
  a_mux_idle: assert property (!ramp_on && mux_rb && readback_select == `RDR_RB_SEL_FREQ |=> !multiplexed_output_pin)
    else $error("readback without ramp");
  a_ext_step: assert property (ext_step_en && slope && !trig_rise && !div_reg_write |=> $stable(divider_word))
    else $error("step without trigger");
  a_down_step: assert property (step_evt && state == rdr_pkg::ST_DOWN && !last_step && !div_reg_write
                                |=> divider_word == $past(divider_word) - $past(delta))
    else $error("down step wrong");

  c_triangle: cover property (state == rdr_pkg::ST_UP ##1 state == rdr_pkg::ST_DOWN);
  c_delay: cover property (state == rdr_pkg::ST_DELAY ##1 state == rdr_pkg::ST_UP);
  c_halt: cover property (halt_evt);
  c_fastlock: cover property (fl_start ##1 wide_bandwidth);

endmodule : rdr_core

// >>> inc/rdr_map.svh
// Constants for the ramp, delay, interrupt and readback sequencer
`ifndef RDR_MAP_SVH
`define RDR_MAP_SVH

// Word widths
`define RDR_INT_W 12
`define RDR_FRAC_W 25
`define RDR_RB_W 37
`define RDR_TMR_W 24
`define RDR_STEP_W 20
`define RDR_DEV_W 16

// Output select and readback select codes
`define RDR_MUX_SEL_RB 4'hF
`define RDR_RB_SEL_FREQ 5'h02
`define RDR_RB_SEL_DONE 5'h03

// Interrupt mode codes
`define RDR_IRQ_OFF 2'h0
`define RDR_IRQ_CONT 2'h1
`define RDR_IRQ_HALT 2'h3

// Ramp type codes and fast lock divider mode
`define RDR_RAMP_SAW 2'h0
`define RDR_RAMP_TRI 2'h1
`define RDR_FL_DIV_MODE 2'h1

// Phase-detector tick derived from the 125 MHz core clock
`define RDR_CORE_PERIOD_NS 8
`define RDR_PFD_PERIOD_NS 40
`define RDR_PFD_CYCLES (`RDR_PFD_PERIOD_NS / `RDR_CORE_PERIOD_NS)

`endif

// >>> inc/rdr_pkg.sv
// Types for the ramp, delay, interrupt and readback sequencer
package rdr_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_UP, ST_DOWN, ST_DELAY, ST_HALT} rdr_state_e;
endpackage : rdr_pkg

// >>> tb/rdr_core_tb.sv
// Self-checking bench for the ramp sequencer
`timescale 1ns/1ps
`include "rdr_map.svh"

module rdr_core_tb;
  localparam int PD = 2;
  logic core_clk, reset_n, div_reg_write, ramp_enable, fast_ramp_en, dual_rate_en, delay_en;
  logic delay_clk_sel, delay_fastlock_en, ext_step_en, trigger_pin, serial_clk;
  logic [1:0] ramp_type, irq_mode, fastlock_mode;
  logic [3:0] output_select, deviation_shift_set0, deviation_shift_set1;
  logic [4:0] readback_select;
  logic [11:0] delay_word, timer_div_one, timer_div_two_set0, timer_div_two_set1;
  logic [`RDR_STEP_W-1:0] step_count_set0, step_count_set1;
  logic [`RDR_DEV_W-1:0] per_step_deviation_word_set0, per_step_deviation_word_set1;
  logic [`RDR_INT_W-1:0] int_value;
  logic [`RDR_FRAC_W-1:0] frac_value;
  logic multiplexed_output_pin, loop_switch_one, loop_switch_two, wide_bandwidth, ramp_active, ramp_complete;
  logic [`RDR_RB_W-1:0] divider_word, rb, hi, lo;
  int fails, check_count, cycles, wb_cnt, ls1_cnt, ls2_cnt, rc_cnt, mux_cnt, p0, pa, pb, w0, s0, t0, r0, m0;

  rdr_core #(.PFD_DIV(PD)) rdr_core_inst (.core_clk, .reset_n, .div_reg_write, .ramp_enable, .int_value,
    .frac_value, .ramp_type, .fast_ramp_en, .dual_rate_en, .delay_en, .delay_clk_sel, .delay_fastlock_en,
    .delay_word, .timer_div_one, .timer_div_two_set0, .timer_div_two_set1, .step_count_set0, .step_count_set1,
    .per_step_deviation_word_set0, .per_step_deviation_word_set1, .deviation_shift_set0, .deviation_shift_set1,
    .ext_step_en, .irq_mode, .output_select, .readback_select, .fastlock_mode, .trigger_pin, .serial_clk,
    .multiplexed_output_pin, .loop_switch_one, .loop_switch_two, .wide_bandwidth, .ramp_active,
    .ramp_complete, .divider_word);
  rdr_host_model rdr_host_model_inst (.core_clk, .multiplexed_output_pin, .trigger_pin, .serial_clk);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Level counters and the hang limit; scenarios take differences, never clear them
  always @(posedge core_clk) begin
    cycles++;
    wb_cnt += int'(wide_bandwidth === 1'b1);
    ls1_cnt += int'(loop_switch_one === 1'b1);
    ls2_cnt += int'(loop_switch_two === 1'b1);
    rc_cnt += int'(ramp_complete === 1'b1);
    mux_cnt += int'(multiplexed_output_pin === 1'b1);
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [`RDR_RB_W-1:0] got, input logic [`RDR_RB_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Divider register write, one-cycle strobe; always the last write of a setup
  task automatic wr(input logic en, input logic [`RDR_RB_W-1:0] b);
    @(posedge core_clk);
    div_reg_write <= 1'b1;
    ramp_enable <= en;
    {int_value, frac_value} <= b;
    @(posedge core_clk);
    div_reg_write <= 1'b0;
  endtask : wr

  // Edges between two burst-complete pulses; bounded so a dead ramp cannot hang
  task automatic gap(output int p);
    int n;
    for (n = 0; n < 3000 && ramp_complete !== 1'b1; n++) @(posedge core_clk);
    @(posedge core_clk);
    for (p = 1; p < 3000 && ramp_complete !== 1'b1; p++) @(posedge core_clk);
  endtask : gap

  task automatic snap();
    {w0, s0, t0, r0, m0} = {wb_cnt, ls1_cnt, ls2_cnt, rc_cnt, mux_cnt};
  endtask : snap

  task automatic t_ext();
    wr(1'b1, 37'h0A0_0100000);
    @(posedge core_clk);
    chk("ramp active", ramp_active, 37'h1);
    chk("start word", divider_word, 37'h0A0_0100000);
    repeat (3) rdr_host_model_inst.pulse();
    repeat (40) @(posedge core_clk);
    chk("stepped word", divider_word, 37'h0A0_0100024);
    ext_step_en <= 1'b0;
  endtask : t_ext

  // Period differences cancel the fixed burst overhead of the design
  task automatic t_delay();
    wr(1'b1, 37'h0A0_0100000);
    gap(p0);
    delay_en <= 1'b1;
    snap();
    wr(1'b1, 37'h0A0_0100000);
    gap(pa);
    gap(pa);
    repeat (3) @(posedge core_clk);
    chk("delay sel0", pa - p0, 5 * PD);
    chk("delay wide bw", wb_cnt - w0, 5 * PD);
    chk("complete on pin", mux_cnt - m0, rc_cnt - r0);
    delay_fastlock_en <= 1'b0;
    delay_clk_sel <= 1'b1;
    wr(1'b1, 37'h0A0_0100000);
    gap(pa);
    gap(pa);
    chk("delay sel1", pa - p0, 5 * 3 * PD);
    delay_clk_sel <= 1'b0;
    dual_rate_en <= 1'b1;
    wr(1'b1, 37'h0A0_0100000);
    gap(pa);
    gap(pb);
    chk("dual rate delay", pa + pb, 2 * p0 + 16 * PD);
    {dual_rate_en, delay_en} <= 2'h0;
  endtask : t_delay

  // Up 2 x 12 and down 3 x 8 give equal excursions
  task automatic t_tri();
    {ramp_type, fast_ramp_en} <= 3'h3;
    wr(1'b1, 37'h0A0_0100000);
    {hi, lo} = {37'h0, 37'h1F_FFFF_FFFF};
    repeat (300) begin
      @(posedge core_clk);
      if (divider_word > hi) hi = divider_word;
      if (divider_word < lo) lo = divider_word;
    end
    chk("tri peak", hi, 37'h0A0_0100018);
    chk("tri floor", lo, 37'h0A0_0100000);
    {ramp_type, fast_ramp_en} <= 3'h0;
  endtask : t_tri

  // Step timer is 12 cycles, so a capture just after start holds the base word
  // Each case is write, trigger pulse, readback (the last adds a stopping write before the readback), as the host sequence asks
  task automatic t_rb();
    {step_count_set0, readback_select, irq_mode} <= {20'h00064, 5'h02, 2'h3};
    wr(1'b1, 37'h01CF623A78);
    rdr_host_model_inst.pulse();
    repeat (60) @(posedge core_clk);
    chk("halted word", divider_word, 37'h01CF623A78);
    rdr_host_model_inst.read_word(rb);
    chk("readback halt", rb, 37'h01CF623A78);
    irq_mode <= 2'h1;
    wr(1'b1, 37'h123_0ABCDEF);
    rdr_host_model_inst.pulse();
    repeat (60) @(posedge core_clk);
    chk("sweep goes on", 37'(divider_word !== 37'h123_0ABCDEF), 37'h1);
    rdr_host_model_inst.read_word(rb);
    chk("readback run", rb, 37'h123_0ABCDEF);
    irq_mode <= 2'h0;
    wr(1'b1, 37'h055_1555555);
    rdr_host_model_inst.pulse();
    rdr_host_model_inst.read_word(rb);
    chk("irq off", rb, 37'h0);
    irq_mode <= 2'h1;
    wr(1'b1, 37'h055_1555555);
    rdr_host_model_inst.pulse();
    wr(1'b0, 37'h055_1555555);
    rdr_host_model_inst.read_word(rb);
    chk("idle readback", rb, 37'h0);
  endtask : t_rb

  task automatic t_fl();
    fastlock_mode <= 2'h1;
    snap();
    wr(1'b0, 37'h0A0_0100000);
    repeat (40) @(posedge core_clk);
    chk("wide bw time", wb_cnt - w0, 3 * 2 * PD);
    chk("switch one", ls1_cnt - s0, 3 * 2 * PD);
    chk("switch two", ls2_cnt - t0, 3 * 2 * PD);
    snap();
    wr(1'b1, 37'h0A0_0100000);
    repeat (40) @(posedge core_clk);
    chk("no fast lock in ramp", wb_cnt - w0, 0);
  endtask : t_fl

  // Main sequence; every input gets a value at time zero
  initial begin
    {div_reg_write, ramp_enable, fast_ramp_en, dual_rate_en, delay_en, delay_clk_sel} = 6'h00;
    {delay_fastlock_en, ext_step_en, ramp_type, irq_mode, fastlock_mode} = 8'hC0;
    {output_select, readback_select, delay_word, timer_div_one} = {4'hF, 5'h03, 12'h005, 12'h003};
    {timer_div_two_set0, timer_div_two_set1, step_count_set0, step_count_set1} = {24'h002002, 20'h2, 20'h3};
    {per_step_deviation_word_set0, per_step_deviation_word_set1} = {16'h0003, 16'h0004};
    {deviation_shift_set0, deviation_shift_set1, int_value, frac_value} = {8'h21, 37'h0};
    {fails, check_count, cycles, wb_cnt, ls1_cnt, ls2_cnt, rc_cnt, mux_cnt} = '0;
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("idle flags", {ramp_active, wide_bandwidth, loop_switch_one, loop_switch_two, ramp_complete}, 37'h0);
    chk("idle word", divider_word, 37'h0);
    {step_count_set0, deviation_shift_set0} <= {20'h00064, 4'h2};
    t_ext();
    {step_count_set0, deviation_shift_set0} <= {20'h00002, 4'h1};
    per_step_deviation_word_set0 <= 16'h0006;
    t_delay();
    t_tri();
    t_rb();
    t_fl();
    close_out();
  end
endmodule : rdr_core_tb

// >>> tb/rdr_host_model.sv
// Host controller model: trigger pulses and serial readback of the divider word
`timescale 1ns/1ps
`include "rdr_map.svh"

module rdr_host_model (
  input wire logic core_clk,
  input wire logic multiplexed_output_pin,
  output logic trigger_pin,
  output logic serial_clk
);
  // Serial clock stands still outside frames
  initial begin
    trigger_pin = 1'b0;
    serial_clk = 1'b0;
  end

  // Held two cycles so the synchronous edge detector cannot miss it
  task automatic pulse();
    @(posedge core_clk);
    trigger_pin <= 1'b1;
    repeat (2) @(posedge core_clk);
    trigger_pin <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse

  // Bit comes out on the rising edge; taken at the falling edge, MSB first
  task automatic read_word(output logic [`RDR_RB_W-1:0] w);
    for (int i = `RDR_RB_W - 1; i >= 0; i--) begin
      @(posedge core_clk);
      serial_clk <= 1'b1;
      repeat (5) @(posedge core_clk);
      serial_clk <= 1'b0;
      w[i] = multiplexed_output_pin;
    end
    @(posedge core_clk);
  endtask : read_word
endmodule : rdr_host_model
